// [dv/ltt_cap_src.sv]
`timescale 1ns/10ps
// ****************************************
// external signal on the capture pin
// ****************************************
module ltt_cap_src
#(
  parameter int DLY = 13
)
(
  // request from bench
  input wire logic fire,
  // pin
  output logic     capture_pin
);
  // level holds between edges; the delay keeps edges off the bus clock
  initial capture_pin = 1'b0;
  always @(posedge fire)
  begin
    capture_pin <= #DLY ~capture_pin;
  end
endmodule

// [dv/ltt_timer_sva.sv]
`timescale 1ns/10ps
// ****************************************
// port-level checks for the lite timer
// ****************************************
module ltt_timer_sva
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // write channels
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // read channels
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [5:0]  s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  // interrupt lines
  input wire logic        tick1_irq,
  input wire logic        tick2_irq,
  input wire logic        capture_irq
);
  import ltt_pkg::*;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // reset must quiet every answer and request line, so it ignores the default disable
  property p_rst_quiet;
    disable iff (1'b0)
    !aresetn |=> !tick1_irq && !tick2_irq && !capture_irq && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  property p_rd_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  property p_rd_one;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  // response comes once both halves of the write are in
  property p_wr_ans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  property p_wr_one;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  // word compare: byte lanes inside the last mapped word are still mapped
  property p_bad_rd;
    s_axi_arvalid && s_axi_arready && s_axi_araddr[5:2] > LTT_OFS_CTRL[5:2]
      |=> s_axi_rresp == LTT_RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  // a clearing read drops the line two edges on, the irq lags its flag
  property p_t1_clr;
    tick1_irq && s_axi_arvalid && s_axi_arready && s_axi_araddr == LTT_OFS_CSR1
      |-> ##2 !tick1_irq;
  endproperty
  property p_t2_clr;
    tick2_irq && s_axi_arvalid && s_axi_arready && s_axi_araddr == LTT_OFS_CSR2
      |-> ##2 !tick2_irq;
  endproperty
  property p_cap_clr;
    capture_irq && s_axi_arvalid && s_axi_arready && s_axi_araddr == LTT_OFS_CAPT
      |-> ##2 !capture_irq;
  endproperty

  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active after reset");
  a_rd_ans: assert property (p_rd_ans) else $error("read data late");
  a_rd_one: assert property (p_rd_one) else $error("read data repeated");
  a_wr_ans: assert property (p_wr_ans) else $error("write response late");
  a_wr_one: assert property (p_wr_one) else $error("write response repeated");
  a_bad_rd: assert property (p_bad_rd) else $error("unmapped read not refused");
  a_t1_clr: assert property (p_t1_clr) else $error("tick1 line not cleared");
  a_t2_clr: assert property (p_t2_clr) else $error("tick2 line not cleared");
  a_cap_clr: assert property (p_cap_clr) else $error("capture line not cleared");

  c_t1: cover property ($rose(tick1_irq));
  c_t2: cover property ($rose(tick2_irq));
  c_cap: cover property ($rose(capture_irq));
endmodule

// [dv/ltt_timer_tb.sv]
`timescale 1ns/10ps
// ****************************************
// bench for the lite timer
// ****************************************
module ltt_timer_tb;
  import ltt_pkg::*;
  // design signals
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, capture_pin, fire;
  logic        tick1_irq, tick2_irq, capture_irq;
  logic [5:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [2:0]  irqs;
  int          cyc = 0;
  int          miscompares = 0;
  int          n_checks = 0;
  int          ta, tz;

  assign irqs = {capture_irq, tick2_irq, tick1_irq};

  ltt_timer i_ltt_timer (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .capture_pin, .tick1_irq, .tick2_irq,
    .capture_irq);
  ltt_cap_src i_ltt_cap_src (.fire, .capture_pin);

  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // ****************************************
  // bus tasks and checks
  // ****************************************
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  // address and data offered together, each released once taken
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    @(posedge aclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= {24'h0, v};
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a);
    @(posedge aclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rdc(input logic [5:0] a, input logic [7:0] e);
    rd(a);
    chk("rdata", d, {24'h0, e});
  endtask

  // waits for an irq line, returns the cycle count when seen
  // one edge first, so a line that a clearing read has just dropped is not seen stale
  task automatic wirq(input int k, output int t);
    @(posedge aclk);
    while (irqs[k] !== 1'b1) @(posedge aclk);
    t = cyc;
  endtask

  task automatic pin();
    @(posedge aclk);
    fire <= 1'b1;
    @(posedge aclk);
    fire <= 1'b0;
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // hang guard, whole run needs about 60000 cycles
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      miscompares++;
      close_out();
    end
  end

  // ****************************************
  // test sequence
  // ****************************************
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, fire} = '0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata  = '0;
    s_axi_wstrb  = 4'hf;
    aresetn      = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(LTT_OFS_CSR2, 8'h00);
    rdc(LTT_OFS_RELOAD, 8'h00);
    rdc(LTT_OFS_CSR1, 8'h00);
    rdc(LTT_OFS_CAPT, 8'h00);
    rdc(LTT_OFS_CTRL, 8'h00);
    wr(LTT_OFS_CSR2, 8'h03);
    rdc(LTT_OFS_CSR2, 8'h02);
    wr(LTT_OFS_RELOAD, 8'hf0);
    rdc(LTT_OFS_RELOAD, 8'hf0);
    wr(LTT_OFS_CSR1, 8'hd8);
    rdc(LTT_OFS_CSR1, 8'h90);
    wr(6'h38, 8'h11);
    chk("bresp", 32'(r), 32'(LTT_RESP_SLVERR));
    rd(6'h38);
    chk("rresp", 32'(r), 32'(LTT_RESP_SLVERR));
    // counter 2 started from zero, so the new reload shows only after the wrap
    wirq(1, ta);
    rdc(LTT_OFS_CNT2, 8'hf0);
    rdc(LTT_OFS_CSR2, 8'h03);
    wirq(1, tz);
    chk("t2 period", 32'(tz - ta), 32'(16 * LTT_PRESCALE));
    // tick 1 already overflowed while waiting on tick 2
    rdc(LTT_OFS_CSR1, 8'h98);
    wirq(0, ta);
    rdc(LTT_OFS_CSR1, 8'h98);
    // edge lands about 620 cycles past the wrap: 19 prescaled ticks
    repeat (614) @(posedge aclk);
    pin();
    repeat (320) @(posedge aclk);
    pin();
    chk("cap irq", {31'h0, capture_irq}, 32'h1);
    rdc(LTT_OFS_CSR1, 8'hd0);
    rdc(LTT_OFS_CAPT, 8'h13);
    repeat (3) @(posedge aclk);
    chk("cap irq", {31'h0, capture_irq}, 32'h0);
    wr(LTT_OFS_CAPT, 8'h55);
    rdc(LTT_OFS_CAPT, 8'h13);
    wirq(0, tz);
    chk("t1 period", 32'(tz - ta), 32'(250 * LTT_PRESCALE));
    wr(LTT_OFS_CSR1, 8'hb0);
    rdc(LTT_OFS_CSR1, 8'hb8);
    wirq(0, ta);
    rdc(LTT_OFS_CSR1, 8'hb8);
    wirq(0, tz);
    chk("t1 double", 32'(tz - ta), 32'(500 * LTT_PRESCALE));
    // halt right after a wrap must freeze counter 2 at the reload value
    rdc(LTT_OFS_CSR2, 8'h03);
    wirq(1, ta);
    wr(LTT_OFS_CTRL, 8'h01);
    repeat (300) @(posedge aclk);
    rdc(LTT_OFS_CNT2, 8'hf0);
    wr(LTT_OFS_CTRL, 8'h00);
    close_out();
  end
endmodule

bind ltt_timer ltt_timer_sva i_ltt_timer_sva (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .s_axi_rresp, .tick1_irq, .tick2_irq, .capture_irq);

// [verilog/ltt_capture_sync.sv]
`timescale 1ns/10ps
// brings the capture pin into the clock domain and reports any edge
module ltt_capture_sync
(
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // pin
  input  wire logic capture_pin,
  // edge pulse
  output logic      edge_seen
);
  import ltt_pkg::*;

  logic meta_r;
  logic sync_r;
  logic last_r;

  // two-stage synchroniser; only sync_r reads meta_r
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end
    else
    begin
      meta_r <= capture_pin;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  // both polarities count
  assign edge_seen = sync_r ^ last_r;

endmodule

// [verilog/ltt_pkg.sv]
package ltt_pkg;

  // ****************************************
  // register byte addresses
  // ****************************************
  localparam logic [5:0] LTT_OFS_CSR2   = 6'h20;
  localparam logic [5:0] LTT_OFS_RELOAD = 6'h24;
  localparam logic [5:0] LTT_OFS_CNT2   = 6'h28;
  localparam logic [5:0] LTT_OFS_CSR1   = 6'h2c;
  localparam logic [5:0] LTT_OFS_CAPT   = 6'h30;
  localparam logic [5:0] LTT_OFS_CTRL   = 6'h34;

  // ****************************************
  // field positions
  // ****************************************
  localparam int LTT_CSR2_FLAG_BIT   = 0;
  localparam int LTT_CSR2_IEN_BIT    = 1;
  localparam int LTT_CSR1_T1F_BIT    = 3;
  localparam int LTT_CSR1_T1IE_BIT   = 4;
  localparam int LTT_CSR1_DBL_BIT    = 5;
  localparam int LTT_CSR1_CAPF_BIT   = 6;
  localparam int LTT_CSR1_CAPIE_BIT  = 7;
  localparam int LTT_CTRL_HALT_BIT   = 0;

  // ****************************************
  // reset values and counts
  // ****************************************
  localparam logic [7:0] LTT_RST_BYTE   = 8'h00;
  localparam logic [7:0] LTT_CNT1_LAST  = 8'hf9;
  localparam logic [7:0] LTT_CNT2_LAST  = 8'hff;
  localparam int         LTT_PRESCALE   = 32;
  localparam logic [4:0] LTT_PRE_LAST   = 5'(LTT_PRESCALE - 1);

  // axi response codes
  localparam logic [1:0] LTT_RESP_OKAY   = 2'h0;
  localparam logic [1:0] LTT_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {LTT_W_IDLE, LTT_W_RESP} ltt_wstate_t;

endpackage

// [verilog/ltt_prescaler.sv]
`timescale 1ns/10ps
// divides the bus clock by the prescale figure, yields a one-cycle tick
module ltt_prescaler
(
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // control
  input  wire logic halt,
  // tick out
  output logic      tick
);
  import ltt_pkg::*;

  logic [4:0] div_r;

  // count continuously unless halted
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      div_r <= 5'h00;
    else if (!halt)
      div_r <= (div_r == LTT_PRE_LAST) ? 5'h00 : div_r + 5'h01;
  end

  assign tick = !halt && (div_r == LTT_PRE_LAST);

endmodule

// [verilog/ltt_timer.sv]
`timescale 1ns/10ps
// Summary of operation
// - counter 1 is internal, eight bits, never readable or writable by software
// - counter 1 starts at zero after reset, advances once per prescaled tick
// - counter 1 overflows wrapping from f9 to 00, 250 states per period
// - period-double bit makes counter 1 overflows twice as far apart
// - counter 1 overflow sets tick-1 flag, irq when tick-1 enable set
// - reading the first control/status register clears tick-1 flag
// - counter 2 readable, starts from reload value after reset, prescaled
// - counter 2 overflows wrapping from ff, then reloads the reload value
// - reload writes take effect only at the next counter 2 overflow
// - counter 2 overflow sets tick-2 flag, irq when tick-2 enable set
// - reading the second control/status register clears tick-2 flag
// - any edge on capture pin while capture flag clear copies counter 1 into capture register
// - each capture sets capture flag, irq when capture enable set
// - reading capture register clears capture flag; register is read-only
// - while capture flag set, further edges leave capture register alone
// - halt stops both counters; slow and wait modes have no effect
// - each event drives its own irq line, gated by its enable
// - second status register: bit 1 tick-2 enable, bit 0 tick-2 flag
// - software writes to the tick-2 flag bit change nothing
// - reload register is an eight-bit read/write field
module ltt_timer
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [5:0]  s_axi_awaddr,
  // axi4-lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // axi4-lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [5:0]  s_axi_araddr,
  // axi4-lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // capture pin
  input  wire logic        capture_pin,
  // interrupt request lines
  output logic             tick1_irq,
  output logic             tick2_irq,
  output logic             capture_irq
);
  import ltt_pkg::*;

  // ****************************************
  // state, submodules and address decode
  // ****************************************
  logic [7:0]  cnt1_r;
  logic        half_r;
  logic [7:0]  counter2_value_r;
  logic [7:0]  counter2_reload_r;
  logic [7:0]  capture_value_r;
  logic        tick1_flag_r;
  logic        tick2_flag_r;
  logic        capture_flag_r;
  logic        tick1_irq_en_r;
  logic        tick2_irq_en_r;
  logic        capture_irq_en_r;
  logic        period_double_sel_r;
  logic        halt_r;
  logic        aw_got_r;
  logic        w_got_r;
  logic [5:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  ltt_wstate_t wstate_r;

  logic tick;
  logic cap_edge;
  logic cnt1_wrap;
  logic tick1_set;
  logic tick2_set;
  logic capture_set;
  logic rd_fire;
  logic wr_do;
  logic rd_csr1;
  logic rd_csr2;
  logic rd_capt;

  ltt_prescaler u_pre
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .halt    (halt_r),
    .tick    (tick)
  );

  ltt_capture_sync u_sync
  (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .capture_pin (capture_pin),
    .edge_seen   (cap_edge)
  );

  // word-aligned compare; low two address bits ignored
  function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
    hit = (a[5:2] == ofs[5:2]);
  endfunction

  function automatic logic mapped(input logic [5:0] a);
    mapped = hit(a, LTT_OFS_CSR2) || hit(a, LTT_OFS_RELOAD) || hit(a, LTT_OFS_CNT2) ||
             hit(a, LTT_OFS_CSR1) || hit(a, LTT_OFS_CAPT) || hit(a, LTT_OFS_CTRL);
  endfunction

  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_csr1 = rd_fire && hit(s_axi_araddr, LTT_OFS_CSR1);
  assign rd_csr2 = rd_fire && hit(s_axi_araddr, LTT_OFS_CSR2);
  assign rd_capt = rd_fire && hit(s_axi_araddr, LTT_OFS_CAPT);
  assign wr_do   = aw_got_r && w_got_r && (wstate_r == LTT_W_IDLE);

  // ****************************************
  // timebase counters
  // ****************************************
  // hidden from the map; no decode reaches it
  assign cnt1_wrap = tick && (cnt1_r == LTT_CNT1_LAST);
  // with doubling, only every second wrap counts as an overflow
  assign tick1_set = cnt1_wrap && (!period_double_sel_r || half_r);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt1_r <= LTT_RST_BYTE;
    else if (cnt1_wrap)
      cnt1_r <= 8'h00;
    else if (tick)
      cnt1_r <= cnt1_r + 8'h01;
  end

  // half-period toggle for the doubled period
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      half_r <= 1'b0;
    else if (cnt1_wrap)
      half_r <= period_double_sel_r ? !half_r : 1'b0;
  end

  assign tick2_set = tick && (counter2_value_r == LTT_CNT2_LAST);

  // reset takes the reload reset value, which is also zero
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      counter2_value_r <= LTT_RST_BYTE;
    else if (tick2_set)
      counter2_value_r <= counter2_reload_r;
    else if (tick)
      counter2_value_r <= counter2_value_r + 8'h01;
  end

  // ****************************************
  // capture and event flags
  // ****************************************
  assign capture_set = cap_edge && !capture_flag_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      capture_value_r <= LTT_RST_BYTE;
    else if (capture_set)
      capture_value_r <= cnt1_r;
  end

  // event flags: a hardware set beats a clearing read in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tick1_flag_r <= 1'b0;
    else if (tick1_set)
      tick1_flag_r <= 1'b1;
    else if (rd_csr1)
      tick1_flag_r <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tick2_flag_r <= 1'b0;
    else if (tick2_set)
      tick2_flag_r <= 1'b1;
    else if (rd_csr2)
      tick2_flag_r <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      capture_flag_r <= 1'b0;
    else if (capture_set)
      capture_flag_r <= 1'b1;
    else if (rd_capt)
      capture_flag_r <= 1'b0;
  end

  // ****************************************
  // software-written control and interrupt lines
  // ****************************************
  // flag bits are never written; upper unused bits are dropped
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      counter2_reload_r   <= LTT_RST_BYTE;
      tick1_irq_en_r      <= 1'b0;
      tick2_irq_en_r      <= 1'b0;
      capture_irq_en_r    <= 1'b0;
      period_double_sel_r <= 1'b0;
      halt_r              <= 1'b0;
    end
    else if (wr_do && wstrb_r[0])
    begin
      if (hit(awaddr_r, LTT_OFS_RELOAD))
        counter2_reload_r <= wdata_r[7:0];
      if (hit(awaddr_r, LTT_OFS_CSR2))
        tick2_irq_en_r <= wdata_r[LTT_CSR2_IEN_BIT];
      if (hit(awaddr_r, LTT_OFS_CSR1))
      begin
        tick1_irq_en_r      <= wdata_r[LTT_CSR1_T1IE_BIT];
        period_double_sel_r <= wdata_r[LTT_CSR1_DBL_BIT];
        capture_irq_en_r    <= wdata_r[LTT_CSR1_CAPIE_BIT];
      end
      if (hit(awaddr_r, LTT_OFS_CTRL))
        halt_r <= wdata_r[LTT_CTRL_HALT_BIT];
    end
  end

  // registered, one line each; the cpu's global mask sits outside this block
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tick1_irq   <= 1'b0;
      tick2_irq   <= 1'b0;
      capture_irq <= 1'b0;
    end
    else
    begin
      tick1_irq   <= tick1_flag_r && tick1_irq_en_r;
      tick2_irq   <= tick2_flag_r && tick2_irq_en_r;
      capture_irq <= capture_flag_r && capture_irq_en_r;
    end
  end

  // ****************************************
  // axi4-lite slave channels
  // ****************************************
  // address and data taken in either order, held until response done
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      awaddr_r      <= 6'h00;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
    end
    else if (wstate_r == LTT_W_RESP && s_axi_bready)
    begin
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_r      <= 1'b1;
        awaddr_r      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_r      <= 1'b1;
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
    end
  end

  // response follows the cycle in which both halves are held
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wstate_r     <= LTT_W_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= LTT_RESP_OKAY;
    end
    else
    begin
      unique case (wstate_r)
        LTT_W_IDLE:
          if (wr_do)
          begin
            wstate_r     <= LTT_W_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(awaddr_r) ? LTT_RESP_OKAY : LTT_RESP_SLVERR;
          end
        LTT_W_RESP:
          if (s_axi_bready)
          begin
            wstate_r     <= LTT_W_IDLE;
            s_axi_bvalid <= 1'b0;
          end
      endcase
    end
  end

  // data captured at the address handshake, so a clearing read returns
  // the flag as it stood before the clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= LTT_RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= mapped(s_axi_araddr) ? LTT_RESP_OKAY : LTT_RESP_SLVERR;
      s_axi_rdata   <= 32'h0000_0000;
      if (hit(s_axi_araddr, LTT_OFS_CSR2))
        s_axi_rdata[1:0] <= {tick2_irq_en_r, tick2_flag_r};
      if (hit(s_axi_araddr, LTT_OFS_RELOAD))
        s_axi_rdata[7:0] <= counter2_reload_r;
      if (hit(s_axi_araddr, LTT_OFS_CNT2))
        s_axi_rdata[7:0] <= counter2_value_r;
      if (hit(s_axi_araddr, LTT_OFS_CSR1))
        s_axi_rdata[7:0] <= {capture_irq_en_r, capture_flag_r, period_double_sel_r,
                             tick1_irq_en_r, tick1_flag_r, 3'b000};
      if (hit(s_axi_araddr, LTT_OFS_CAPT))
        s_axi_rdata[7:0] <= capture_value_r;
      if (hit(s_axi_araddr, LTT_OFS_CTRL))
        s_axi_rdata[0] <= halt_r;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule
